// File: design/iswr_pkg.sv
package iswr_pkg;

  // Register map of the command port, byte offsets
  localparam logic [3:0] OFS_CODE = 4'h0;
  localparam logic [3:0] OFS_ANS  = 4'h4;
  localparam logic [3:0] OFS_RDAT = 4'h8;
  localparam logic [3:0] OFS_CFG  = 4'hc;

  // Configuration register fields
  localparam int unsigned CFG_TWO_ST_BIT = 0;

  // Supported read instruction codes
  localparam logic [15:0] CODE_IN0  = 16'h0040;
  localparam logic [15:0] CODE_IN1  = 16'h0041;
  localparam logic [15:0] CODE_IN2  = 16'h0042;
  localparam logic [15:0] CODE_OUT0 = 16'h0050;
  localparam logic [15:0] CODE_OUT1 = 16'h0051;

  // Answer codes and reset values
  localparam logic [15:0] ANS_OK    = 16'h0000;
  localparam logic [15:0] ANS_ERR   = 16'h0001;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [1:0]  RST_MC    = 2'h0;

  // Input status word 0, bit F down to bit 0
  typedef struct packed {
    logic       unused_f;
    logic [4:0] point_sel_5_1;
    logic       code_exec_request;
    logic       monitor_request;
    logic       temp_stop_restart;
    logic       auto_manual_sel;
    logic       rev_stroke_end;
    logic       fwd_stroke_end;
    logic       prox_dog;
    logic       rev_start;
    logic       fwd_start;
    logic       servo_on;
  } iswr_in0_s;

  // Input status word 1
  typedef struct packed {
    logic [3:0] unused_f_c;
    logic       incremental_sel;
    logic       clear_sel;
    logic       unused_9;
    logic       gain_switch;
    logic       proportional_ctrl;
    logic       torque_limit_sel;
    logic [2:0] point_sel_8_6;
    logic       unused_2;
    logic       spd_cmd_request;
    logic       pos_cmd_request;
  } iswr_in1_s;

  // Input status word 2
  typedef struct packed {
    logic [4:0] unused_f_b;
    logic       alarm_reset;
    logic [9:0] unused_9_0;
  } iswr_in2_s;

  // Output status word 0
  typedef struct packed {
    logic unused_f;
    logic position_range;
    logic unused_d;
    logic travel_done;
    logic battery_warning;
    logic warning_out;
    logic code_exec_done;
    logic monitoring_active;
    logic temp_stopped;
    logic brake_interlock;
    logic unused_5;
    logic torque_limiting;
    logic home_done;
    logic rough_match;
    logic in_position;
    logic ready_out;
  } iswr_out0_s;

  // Output status word 1
  typedef struct packed {
    logic [5:0] unused_f_a;
    logic [7:0] point_out_8_1;
    logic       spd_cmd_done;
    logic       pos_cmd_done;
  } iswr_out1_s;

endpackage

// File: design/iswr_top.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module iswr_top #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // Command port
  input  wire logic [ADDR_W-1:0]    bus_addr,
  input  wire logic [15:0]          bus_wdata,
  input  wire logic                 bus_wr,
  input  wire logic                 bus_rd,
  output logic      [15:0]          bus_rdata,
  // Signal states
  input  wire iswr_pkg::iswr_in0_s  in_w0,
  input  wire iswr_pkg::iswr_in1_s  in_w1,
  input  wire iswr_pkg::iswr_in2_s  in_w2,
  input  wire iswr_pkg::iswr_out0_s out_w0,
  input  wire iswr_pkg::iswr_out1_s out_w1,
  input  wire logic [1:0]           monitor_code,
  // Answer
  output logic      [15:0]          read_data_word,
  output logic      [15:0]          answer_code_word,
  output logic      [1:0]           monitor_code_rep
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W must be at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [15:0]         code_ff;
  logic [15:0]         rdat_ff;
  logic [15:0]         ans_ff;
  logic                two_st_ff;
  logic [1:0]          mc_ff;
  logic [15:0]         rd_ff;
  logic [15:0]         nxt_rdat;
  logic [15:0]         nxt_ans;
  logic [15:0]         nxt_rd;
  logic [1:0]          nxt_mc;
  iswr_pkg::iswr_in0_s  w_in0;
  iswr_pkg::iswr_in1_s  w_in1;
  iswr_pkg::iswr_in2_s  w_in2;
  iswr_pkg::iswr_out0_s w_out0;
  iswr_pkg::iswr_out1_s w_out1;
  wire [3:0]           a_lo   = bus_addr[3:0];
  wire                 a_hi_z = (bus_addr >> 4) == '0;
  wire                 hit_code = a_hi_z && (a_lo == iswr_pkg::OFS_CODE);
  wire                 hit_ans  = a_hi_z && (a_lo == iswr_pkg::OFS_ANS);
  wire                 hit_rdat = a_hi_z && (a_lo == iswr_pkg::OFS_RDAT);
  wire                 hit_cfg  = a_hi_z && (a_lo == iswr_pkg::OFS_CFG);
  wire                 take_code = bus_wr && hit_code;
  wire                 take_cfg  = bus_wr && hit_cfg;
  wire [15:0]          new_code  = bus_wdata;
  wire                 s_in0  = new_code == iswr_pkg::CODE_IN0;
  wire                 s_in1  = new_code == iswr_pkg::CODE_IN1;
  wire                 s_in2  = new_code == iswr_pkg::CODE_IN2;
  wire                 s_out0 = new_code == iswr_pkg::CODE_OUT0;
  wire                 s_out1 = new_code == iswr_pkg::CODE_OUT1;
  wire                 s_any  = s_in0 | s_in1 | s_in2 | s_out0 | s_out1;

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly

  always_comb begin
    w_in0 = in_w0;
    w_in0.unused_f = 1'b0;
    if (two_st_ff) begin
      w_in0.point_sel_5_1[2:0] = 3'h0;
    end
  end

  always_comb begin
    w_in1 = in_w1;
    w_in1.unused_f_c = 4'h0;
    w_in1.unused_9   = 1'b0;
    w_in1.unused_2   = 1'b0;
  end

  always_comb begin
    w_in2 = in_w2;
    w_in2.unused_f_b = 5'h00;
    w_in2.unused_9_0 = 10'h000;
  end

  always_comb begin
    w_out0 = out_w0;
    w_out0.unused_f = 1'b0;
    w_out0.unused_d = 1'b0;
    w_out0.unused_5 = 1'b0;
  end

  always_comb begin
    w_out1 = out_w1;
    w_out1.unused_f_a = 6'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word selection and answer

  assign nxt_rdat = s_in0  ? 16'(w_in0)  :
                    s_in1  ? 16'(w_in1)  :
                    s_in2  ? 16'(w_in2)  :
                    s_out0 ? 16'(w_out0) :
                    s_out1 ? 16'(w_out1) :
                    iswr_pkg::ZERO_WORD;
  assign nxt_ans  = s_any ? iswr_pkg::ANS_OK : iswr_pkg::ANS_ERR;
  assign nxt_mc   = two_st_ff ? 2'h0 : monitor_code;

  assign nxt_rd = !bus_rd  ? iswr_pkg::ZERO_WORD :
                  hit_code ? code_ff :
                  hit_ans  ? ans_ff :
                  hit_rdat ? rdat_ff :
                  hit_cfg  ? {15'h0000, two_st_ff} :
                  iswr_pkg::ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_ff <= iswr_pkg::RST_WORD;
      rdat_ff <= iswr_pkg::RST_WORD;
      ans_ff  <= iswr_pkg::ANS_OK;
    end else if (take_code) begin
      code_ff <= new_code;
      rdat_ff <= nxt_rdat;
      ans_ff  <= nxt_ans;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      two_st_ff <= 1'b0;
    end else if (take_cfg) begin
      two_st_ff <= bus_wdata[iswr_pkg::CFG_TWO_ST_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ff <= iswr_pkg::RST_WORD;
      mc_ff <= iswr_pkg::RST_MC;
    end else begin
      rd_ff <= nxt_rd;
      mc_ff <= nxt_mc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus_rdata        = rd_ff;
  assign read_data_word   = rdat_ff;
  assign answer_code_word = ans_ff;
  assign monitor_code_rep = mc_ff;

endmodule

// File: verification/iswr_monitor.sv
`timescale 1ns/100ps
module iswr_monitor #(
  parameter int ADDR_W = 4
) (
  // Clock, reset and command port
  input wire logic                 ref_clk,
  input wire logic                 rst_b,
  input wire logic [ADDR_W-1:0]    bus_addr,
  input wire logic [15:0]          bus_wdata,
  input wire logic                 bus_wr,
  input wire logic                 bus_rd,
  input wire logic [15:0]          bus_rdata,
  // Signal states
  input wire iswr_pkg::iswr_in0_s  in_w0,
  input wire iswr_pkg::iswr_in1_s  in_w1,
  input wire iswr_pkg::iswr_in2_s  in_w2,
  input wire iswr_pkg::iswr_out0_s out_w0,
  input wire iswr_pkg::iswr_out1_s out_w1,
  input wire logic [1:0]           monitor_code,
  // Answer
  input wire logic [15:0]          read_data_word,
  input wire logic [15:0]          answer_code_word,
  input wire logic [1:0]           monitor_code_rep
);
  logic        two_ff;
  logic [15:0] exp_w;
  wire         wr_code = bus_wr && bus_addr == iswr_pkg::OFS_CODE;
  wire         known = bus_wdata inside {16'h0040, 16'h0041, 16'h0042, 16'h0050, 16'h0051};
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) two_ff <= 1'b0;
    else if (bus_wr && bus_addr == iswr_pkg::OFS_CFG) two_ff <= bus_wdata[0];
  always_comb
    case (bus_wdata)
      16'h0040: exp_w = in_w0 & (two_ff ? 16'h63ff : 16'h7fff);
      16'h0041: exp_w = in_w1 & 16'h0dfb;
      16'h0042: exp_w = in_w2 & 16'h0400;
      16'h0050: exp_w = out_w0 & 16'h5fdf;
      16'h0051: exp_w = out_w1 & 16'h03ff;
      default:  exp_w = 16'h0000;
    endcase
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_word_snap: assert property (wr_code |=> read_data_word == $past(exp_w))
    else $error("read data word differs from snapshot");
  a_answer_code: assert property (wr_code |=> answer_code_word ==
    ($past(known) ? iswr_pkg::ANS_OK : iswr_pkg::ANS_ERR)) else $error("wrong answer code");
  a_two_station: assert property (wr_code && two_ff && bus_wdata == 16'h0040
    |=> read_data_word[12:10] == 3'h0) else $error("point select bits not zero");
  a_word_hold: assert property (!wr_code |=> $stable(read_data_word))
    else $error("read data word changed without code");
  a_mon_rep: assert property (##1 monitor_code_rep ==
    ($past(two_ff) ? 2'h0 : $past(monitor_code))) else $error("monitor code report wrong");
  a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero outside read");
  a_rd_word: assert property (bus_rd && bus_addr == iswr_pkg::OFS_RDAT
    |=> bus_rdata == $past(read_data_word)) else $error("read of data word wrong");
  a_rd_answer: assert property (bus_rd && bus_addr == iswr_pkg::OFS_ANS
    |=> bus_rdata == $past(answer_code_word)) else $error("read of answer wrong");
  c_bad_code: cover property (wr_code && !known);
  c_two_word: cover property (wr_code && two_ff && bus_wdata == 16'h0040);
  c_rd_word: cover property (bus_rd && bus_addr == iswr_pkg::OFS_RDAT);
endmodule
bind iswr_top iswr_monitor #(.ADDR_W(ADDR_W)) u_monitor (.*);

// File: verification/iswr_plc_model.sv
`timescale 1ns/100ps
module iswr_plc_model (
  // Clock and command port
  input wire logic        ref_clk,
  output logic     [3:0]  bus_addr,
  output logic     [15:0] bus_wdata,
  output logic            bus_wr,
  output logic            bus_rd,
  input wire logic [15:0] bus_rdata
);
  initial {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
  // One-cycle strobes; a released bus shows the inverted value
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  task automatic rd(logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1 d = bus_rdata;
  endtask
endmodule

// File: verification/iswr_tb_top.sv
`timescale 1ns/100ps
module iswr_tb_top;
  logic                 ref_clk, rst_b, bus_wr, bus_rd, two;
  logic [3:0]           bus_addr;
  logic [15:0]          bus_wdata, bus_rdata, read_data_word, answer_code_word, e, a, d;
  logic [1:0]           monitor_code, monitor_code_rep;
  iswr_pkg::iswr_in0_s  in_w0;
  iswr_pkg::iswr_in1_s  in_w1;
  iswr_pkg::iswr_in2_s  in_w2;
  iswr_pkg::iswr_out0_s out_w0;
  iswr_pkg::iswr_out1_s out_w1;
  int                   n_mismatch, n_compared;
  logic [15:0]          codes [8] = '{16'h0040, 16'h0041, 16'h0042, 16'h0050, 16'h0051,
                                      16'h0000, 16'h0aff, 16'h0052};
  iswr_top       dut (.*);
  iswr_plc_model u_plc (.*);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_word(logic [15:0] code, logic two_st);
    case (code)
      16'h0040: return in_w0 & (two_st ? 16'h63ff : 16'h7fff);
      16'h0041: return in_w1 & 16'h0dfb;
      16'h0042: return in_w2 & 16'h0400;
      16'h0050: return out_w0 & 16'h5fdf;
      16'h0051: return out_w1 & 16'h03ff;
      default:  return 16'h0000;
    endcase
  endfunction
  task automatic scramble();
    {in_w0, in_w1} <= $urandom;
    {in_w2, out_w0} <= $urandom;
    {out_w1, monitor_code} <= 18'($urandom);
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    {in_w0, in_w1, in_w2, out_w0, out_w1, monitor_code} = '0;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(13199));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int t = 0; t < 32; t++) begin
      two = t[3];
      u_plc.wr(iswr_pkg::OFS_CFG, {15'h0000, two});
      scramble();
      u_plc.wr(iswr_pkg::OFS_CODE, codes[t % 8]);
      e = exp_word(codes[t % 8], two);
      a = (t % 8 < 5) ? iswr_pkg::ANS_OK : iswr_pkg::ANS_ERR;
      scramble();
      @(posedge ref_clk);
      #1;
      chk("read_data_word", e, read_data_word);
      chk("answer_code_word", a, answer_code_word);
      chk("monitor_code_rep", {14'h0, two ? 2'h0 : monitor_code}, {14'h0, monitor_code_rep});
      u_plc.rd(iswr_pkg::OFS_RDAT, d);
      chk("bus_rdata word", e, d);
      u_plc.rd(iswr_pkg::OFS_ANS, d);
      chk("bus_rdata answer", a, d);
      u_plc.rd({t[1:0], 2'h2}, d);
      chk("bus_rdata unmapped", 16'h0000, d);
    end
    conclude();
  end
endmodule
